// *** src/cftc_top.sv ***
// Fault qualification and gate-drive control for a single-cell protector, with an Avalon-MM status slave.
// Assumes comparator flags and option straps arrive asynchronously from analog and fuse logic.
//
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/10ps
module cftc_top
  import cftc_pkg::*;
#(
  parameter int               CW      = 32,
  parameter logic [3:0][31:0] OVP_DLY = OVP_DLY_CYC,
  parameter logic [3:0][31:0] UVP_DLY = UVP_DLY_CYC,
  parameter logic [3:0][31:0] OCD_DLY = OCD_DLY_CYC,
  parameter logic [3:0][31:0] OCC_DLY = OCC_DLY_CYC,
  parameter logic [31:0]      SCC_DLY = SCC_DLY_CYC,
  parameter logic [31:0]      REC_DLY = REC_DLY_CYC
)
(
  input  wire logic         CLK,
  input  wire logic         RST,
  input  wire logic         CE,
  input  wire cftc_cmp_type CMP_IN,
  input  wire cftc_cfg_type CFG_IN,
  input  wire logic [3:0]   AVS_ADDRESS,
  input  wire logic         AVS_READ,
  input  wire logic         AVS_WRITE,
  input  wire logic [31:0]  AVS_WRITEDATA,
  input  wire logic [3:0]   AVS_BYTEENABLE,
  output logic [31:0]       AVS_READDATA,
  output logic              AVS_WAITREQUEST,
  output logic              CHARGE_GATE_OUT,
  output logic              DISCHARGE_GATE_OUT,
  output cftc_thr_type      THR_OUT,
  output logic [4:0]        FAULT_STATUS,
  output logic              CFG_READY
);

  // Clamps a threshold code to the top of its span.
  function automatic logic [4:0] clamp_code(input logic [4:0] code, input logic [4:0] top);
    return (code > top) ? top : code;
  endfunction : clamp_code

  cftc_cmp_type    cmp_meta_q;
  cftc_cmp_type    cmp_q;
  cftc_cfg_type    cfg_meta_q;
  cftc_cfg_type    cfg_sync_q;
  cftc_cfg_type    cfg_q;
  logic [1:0]      settle_q;
  logic            init_q;
  logic            force_off_q;
  logic            cfg_ready_q;
  logic [NUM_FAULTS-1:0]         flt_det;
  logic [NUM_FAULTS-1:0]         flt_rel;
  logic [NUM_FAULTS-1:0]         flt_lat;
  logic [NUM_FAULTS-1:0][CW-1:0] det_lim;
  logic            depleted;
  logic            zv_ok;
  logic            chg_on_d;
  logic            dsg_on_d;
  logic            normal_window;
  logic            bus_req;
  logic [31:0]     rd_d;

  // Two-flop synchronisers for comparator flags and option straps.
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      cmp_meta_q <= '0;
      cmp_q      <= '0;
      cfg_meta_q <= '0;
      cfg_sync_q <= '0;
    end
    else if (CE)
    begin
      cmp_meta_q <= CMP_IN;
      cmp_q      <= cmp_meta_q;
      cfg_meta_q <= CFG_IN;
      cfg_sync_q <= cfg_meta_q;
    end
  end

  // Options are captured once after reset release and then held.
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      settle_q    <= '0;
      cfg_q       <= '0;
      cfg_ready_q <= 1'b0;
    end
    else if (CE)
    begin
      if (settle_q != SETTLE_DONE)
        settle_q <= settle_q + 2'h1;
      if (settle_q == SETTLE_CFG)
      begin
        cfg_q       <= cfg_sync_q;
        cfg_ready_q <= 1'b1;
      end
    end
  end

  // Threshold codes driven to the analog comparators.
  always_ff @(posedge CLK)
  begin
    if (RST)
      THR_OUT <= '0;
    else if (CE)
    begin
      THR_OUT.overcharge_thr    <= cfg_q.overcharge_thr_sel;
      THR_OUT.overdischarge_thr <= clamp_code(cfg_q.overdischarge_thr_sel, UVP_CODE_MAX);
      THR_OUT.discharge_oc_thr  <= clamp_code(cfg_q.discharge_oc_thr_sel, OCD_CODE_MAX);
      THR_OUT.charge_oc_thr     <= clamp_code(cfg_q.charge_oc_thr_sel, OCC_CODE_MAX);
      THR_OUT.short_thr         <= cfg_q.short_thr_sel;
    end
  end

  // Detection and release conditions and delay selection per fault.
  always_comb
  begin
    flt_det = '0;
    flt_rel = '0;
    det_lim = '0;
    flt_det[FI_OVP] = cmp_q.overcharge_fault;
    flt_rel[FI_OVP] = cmp_q.overcharge_release;
    det_lim[FI_OVP] = CW'(OVP_DLY[cfg_q.overcharge_delay_sel]);
    flt_det[FI_UVP] = cmp_q.overdischarge_fault;
    flt_rel[FI_UVP] = cmp_q.overdischarge_release;
    det_lim[FI_UVP] = CW'(UVP_DLY[cfg_q.overdischarge_delay_sel]);
    flt_det[FI_OCD] = cmp_q.discharge_overcurrent_fault;
    flt_rel[FI_OCD] = cmp_q.load_released;
    det_lim[FI_OCD] = CW'(OCD_DLY[cfg_q.discharge_oc_delay_sel]);
    flt_det[FI_SCC] = cmp_q.load_short_fault;
    flt_rel[FI_SCC] = cmp_q.load_released;
    det_lim[FI_SCC] = CW'(SCC_DLY);
    flt_det[FI_OCC] = cmp_q.charge_overcurrent_fault;
    flt_rel[FI_OCC] = cmp_q.charge_oc_release;
    det_lim[FI_OCC] = CW'(OCC_DLY[cfg_q.charge_oc_delay_sel]);
  end

  // One qualifier per fault; reset clears every timer.
  generate
    for (genvar i = 0; i < NUM_FAULTS; i++)
    begin : g_fault
      cftc_fault #(
        .CW (CW)
      ) u_fault (
        .clk        (CLK),
        .rst        (RST),
        .ce         (CE && cfg_ready_q),
        .detect     (flt_det[i]),
        .release_ok (flt_rel[i]),
        .det_limit  (det_lim[i]),
        .rec_limit  (CW'(REC_DLY)),
        .latched    (flt_lat[i])
      );
    end
  endgenerate

  // Gates stay off after reset until inputs settle inside the normal window.
  assign normal_window = ~(|flt_det);

  always_ff @(posedge CLK)
  begin
    if (RST)
      init_q <= 1'b1;
    else if (CE && (settle_q == SETTLE_DONE) && normal_window)
      init_q <= 1'b0;
  end

  // Zero-volt charge handling for a depleted cell.
  assign depleted = cmp_q.zero_volt_charge_inhibit;
  assign zv_ok    = cfg_q.zero_volt_allow && cmp_q.zero_volt_charge_start;

  always_comb
  begin
    chg_on_d = ~init_q && ~force_off_q && ~flt_lat[FI_OVP] && ~flt_lat[FI_OCC];
    if (depleted)
      chg_on_d = chg_on_d && zv_ok;
    dsg_on_d = ~init_q && ~force_off_q && ~flt_lat[FI_UVP] && ~flt_lat[FI_OCD] && ~flt_lat[FI_SCC];
  end

  // High drives the FET on, low turns it off.
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      CHARGE_GATE_OUT    <= 1'b0;
      DISCHARGE_GATE_OUT <= 1'b0;
      FAULT_STATUS       <= '0;
      CFG_READY          <= 1'b0;
    end
    else if (CE)
    begin
      CHARGE_GATE_OUT    <= chg_on_d;
      DISCHARGE_GATE_OUT <= dsg_on_d;
      FAULT_STATUS       <= flt_lat;
      CFG_READY          <= cfg_ready_q;
    end
  end

  // Avalon-MM slave: one wait cycle, then the access completes.
  assign bus_req = AVS_READ || AVS_WRITE;

  always_comb
  begin
    rd_d = '0;
    case (AVS_ADDRESS)
      REG_STATUS:
      begin
        rd_d[NUM_FAULTS-1:0] = FAULT_STATUS;
        rd_d[ST_CHG_BIT]     = CHARGE_GATE_OUT;
        rd_d[ST_DSG_BIT]     = DISCHARGE_GATE_OUT;
        rd_d[ST_INIT_BIT]    = init_q;
        rd_d[ST_READY_BIT]   = cfg_ready_q;
      end
      REG_CFG:
        rd_d[$bits(cftc_cfg_type)-1:0] = cfg_q;
      REG_CTRL:
        rd_d[CTRL_OFF_BIT] = force_off_q;
      default:
        rd_d = '0;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= '0;
    end
    else if (CE)
    begin
      if (bus_req && AVS_WAITREQUEST)
      begin
        AVS_WAITREQUEST <= 1'b0;
        AVS_READDATA    <= AVS_READ ? rd_d : 32'h0;
      end
      else
        AVS_WAITREQUEST <= 1'b1;
    end
  end

  // Software gate-off control, written on the completing cycle.
  always_ff @(posedge CLK)
  begin
    if (RST)
      force_off_q <= CTRL_OFF_RST;
    else if (CE && AVS_WRITE && !AVS_WAITREQUEST && (AVS_ADDRESS == REG_CTRL) && AVS_BYTEENABLE[0])
      force_off_q <= AVS_WRITEDATA[CTRL_OFF_BIT];
  end

endmodule : cftc_top

// *** src/cftc_pkg.sv ***
// Shared constants, delay counts and carrier types of the cell fault timer control block.
// Assumes a single 125 MHz clock; all delay counts are derived from its period.
package cftc_pkg;

  localparam int unsigned CLK_PERIOD_NS = 8;

  // Counts one time in microseconds as whole clock cycles, never less than one.
  function automatic logic [31:0] cftc_cyc(input longint unsigned t_us);
    longint unsigned c;
    c = (t_us * 64'd1000) / CLK_PERIOD_NS;
    if (c < 64'd1)
      c = 64'd1;
    return c[31:0];
  endfunction : cftc_cyc

  // Threshold option spans in millivolts and the top code of each stepped span.
  localparam int OVP_MIN_MV    = 3850;
  localparam int OVP_MAX_MV    = 4600;
  localparam int OVP_STEP_MV   = 50;
  localparam int UVP_MIN_MV    = 2000;
  localparam int UVP_MAX_MV    = 2800;
  localparam int UVP_STEP_MV   = 50;
  localparam int OCD_MIN_MV    = 90;
  localparam int OCD_MAX_MV    = 200;
  localparam int OCD_STEP_MV   = 5;
  localparam int OCC_MIN_MV    = -45;
  localparam int OCC_MAX_MV    = -155;
  localparam int OCC_STEP_MV   = 5;
  localparam int SCC_MIN_MV    = 300;
  localparam int SCC_MAX_MV    = 600;
  localparam logic [4:0] OVP_CODE_MAX = 5'((OVP_MAX_MV - OVP_MIN_MV) / OVP_STEP_MV);
  localparam logic [4:0] UVP_CODE_MAX = 5'((UVP_MAX_MV - UVP_MIN_MV) / UVP_STEP_MV);
  localparam logic [4:0] OCD_CODE_MAX = 5'((OCD_MAX_MV - OCD_MIN_MV) / OCD_STEP_MV);
  localparam logic [4:0] OCC_CODE_MAX = 5'((OCC_MIN_MV - OCC_MAX_MV) / OCC_STEP_MV);

  // Delay options in microseconds, indexed by the two-bit option code; the short-circuit and recovery delays are single values.
  localparam longint unsigned OVP_DLY0_US = 250000;
  localparam longint unsigned OVP_DLY1_US = 1000000;
  localparam longint unsigned OVP_DLY2_US = 1250000;
  localparam longint unsigned OVP_DLY3_US = 4500000;
  localparam longint unsigned UVP_DLY0_US = 20000;
  localparam longint unsigned UVP_DLY1_US = 96000;
  localparam longint unsigned UVP_DLY2_US = 125000;
  localparam longint unsigned UVP_DLY3_US = 144000;
  localparam longint unsigned OCD_DLY0_US = 8000;
  localparam longint unsigned OCD_DLY1_US = 16000;
  localparam longint unsigned OCD_DLY2_US = 20000;
  localparam longint unsigned OCD_DLY3_US = 48000;
  localparam longint unsigned OCC_DLY0_US = 4000;
  localparam longint unsigned OCC_DLY1_US = 6000;
  localparam longint unsigned OCC_DLY2_US = 8000;
  localparam longint unsigned OCC_DLY3_US = 16000;
  localparam longint unsigned SCC_DLY_US  = 250;
  localparam longint unsigned REC_DLY_US  = 1000;

  localparam logic [3:0][31:0] OVP_DLY_CYC = {cftc_cyc(OVP_DLY3_US), cftc_cyc(OVP_DLY2_US),
                                              cftc_cyc(OVP_DLY1_US), cftc_cyc(OVP_DLY0_US)};
  localparam logic [3:0][31:0] UVP_DLY_CYC = {cftc_cyc(UVP_DLY3_US), cftc_cyc(UVP_DLY2_US),
                                              cftc_cyc(UVP_DLY1_US), cftc_cyc(UVP_DLY0_US)};
  localparam logic [3:0][31:0] OCD_DLY_CYC = {cftc_cyc(OCD_DLY3_US), cftc_cyc(OCD_DLY2_US),
                                              cftc_cyc(OCD_DLY1_US), cftc_cyc(OCD_DLY0_US)};
  localparam logic [3:0][31:0] OCC_DLY_CYC = {cftc_cyc(OCC_DLY3_US), cftc_cyc(OCC_DLY2_US),
                                              cftc_cyc(OCC_DLY1_US), cftc_cyc(OCC_DLY0_US)};
  localparam logic [31:0]      SCC_DLY_CYC = cftc_cyc(SCC_DLY_US);
  localparam logic [31:0]      REC_DLY_CYC = cftc_cyc(REC_DLY_US);

  // Fault indices.
  localparam int NUM_FAULTS = 5;
  localparam int FI_OVP     = 0;
  localparam int FI_UVP     = 1;
  localparam int FI_OCD     = 2;
  localparam int FI_SCC     = 3;
  localparam int FI_OCC     = 4;

  // Start-up settle count covering the input synchronisers.
  localparam logic [1:0] SETTLE_CFG  = 2'h2;
  localparam logic [1:0] SETTLE_DONE = 2'h3;

  // Register byte offsets and fields.
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CFG    = 4'h4;
  localparam logic [3:0] REG_CTRL   = 4'h8;
  localparam int ST_CHG_BIT   = 5;
  localparam int ST_DSG_BIT   = 6;
  localparam int ST_INIT_BIT  = 7;
  localparam int ST_READY_BIT = 8;
  localparam int CTRL_OFF_BIT = 0;
  localparam logic CTRL_OFF_RST = 1'b0;

  typedef struct packed {
    logic overcharge_fault;
    logic overcharge_release;
    logic overdischarge_fault;
    logic overdischarge_release;
    logic discharge_overcurrent_fault;
    logic load_short_fault;
    logic load_released;
    logic charge_overcurrent_fault;
    logic charge_oc_release;
    logic zero_volt_charge_start;
    logic zero_volt_charge_inhibit;
  } cftc_cmp_type;

  typedef struct packed {
    logic       zero_volt_allow;
    logic [1:0] charge_oc_delay_sel;
    logic [1:0] discharge_oc_delay_sel;
    logic [1:0] overdischarge_delay_sel;
    logic [1:0] overcharge_delay_sel;
    logic [1:0] short_thr_sel;
    logic [4:0] charge_oc_thr_sel;
    logic [4:0] discharge_oc_thr_sel;
    logic [4:0] overdischarge_thr_sel;
    logic [3:0] overcharge_thr_sel;
  } cftc_cfg_type;

  typedef struct packed {
    logic [1:0] short_thr;
    logic [4:0] charge_oc_thr;
    logic [4:0] discharge_oc_thr;
    logic [4:0] overdischarge_thr;
    logic [3:0] overcharge_thr;
  } cftc_thr_type;

  typedef enum logic [1:0] {
    FL_IDLE    = 2'b00,
    FL_DETECT  = 2'b01,
    FL_FAULT   = 2'b10,
    FL_RECOVER = 2'b11
  } cftc_fl_state_type;

endpackage : cftc_pkg

// *** src/cftc_fault.sv ***
// One fault qualifier: detection delay, latched fault and recovery delay.
// Assumes detect and release come from synchronised flags on the same clock.
`timescale 1ns/10ps
module cftc_fault
  import cftc_pkg::*;
#(
  parameter int CW = 32
)
(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          ce,
  input  wire logic          detect,
  input  wire logic          release_ok,
  input  wire logic [CW-1:0] det_limit,
  input  wire logic [CW-1:0] rec_limit,
  output logic               latched
);

  cftc_fl_state_type state_q;
  logic [CW-1:0]     cnt_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= FL_IDLE;
      cnt_q   <= '0;
    end
    else if (ce)
    begin
      case (state_q)
        FL_IDLE:
        begin
          cnt_q <= '0;
          if (detect)
            state_q <= FL_DETECT;
        end
        FL_DETECT:
        begin
          if (!detect)
          begin
            state_q <= FL_IDLE;
            cnt_q   <= '0;
          end
          else if (cnt_q >= det_limit - 1'b1)
          begin
            state_q <= FL_FAULT;
            cnt_q   <= '0;
          end
          else
            cnt_q <= cnt_q + 1'b1;
        end
        FL_FAULT:
        begin
          cnt_q <= '0;
          if (release_ok && !detect)
            state_q <= FL_RECOVER;
        end
        FL_RECOVER:
        begin
          if (detect || !release_ok)
          begin
            state_q <= FL_FAULT;
            cnt_q   <= '0;
          end
          else if (cnt_q >= rec_limit - 1'b1)
          begin
            state_q <= FL_IDLE;
            cnt_q   <= '0;
          end
          else
            cnt_q <= cnt_q + 1'b1;
        end
        default:
        begin
          state_q <= FL_IDLE;
          cnt_q   <= '0;
        end
      endcase
    end
  end

  assign latched = (state_q == FL_FAULT) || (state_q == FL_RECOVER);

endmodule : cftc_fault

// *** test/cftc_fet_model.sv ***
// Model of the external charge and discharge power FETs driven by the gate outputs.
// Assumes the gates are logic-level outputs of the block under test.
`timescale 1ns/10ps
module cftc_fet_model
(
  input  wire logic chg_gate,
  input  wire logic dsg_gate,
  output logic      chg_on,
  output logic      dsg_on
);
  // A high gate turns a FET on, a low gate turns it off.
  assign chg_on = chg_gate;
  assign dsg_on = dsg_gate;
endmodule : cftc_fet_model

// *** test/cftc_checker.sv ***
// Concurrent checks on the ports of the fault timer control top.
// Assumes it is bound into cftc_top and CFG_IN is held stable after reset.
`timescale 1ns/10ps
module cftc_checker
  import cftc_pkg::*;
#(
  parameter logic [3:0][31:0] OVP_DLY = OVP_DLY_CYC,
  parameter logic [3:0][31:0] UVP_DLY = UVP_DLY_CYC,
  parameter logic [3:0][31:0] OCD_DLY = OCD_DLY_CYC,
  parameter logic [3:0][31:0] OCC_DLY = OCC_DLY_CYC,
  parameter logic [31:0]      SCC_DLY = SCC_DLY_CYC
)
(
  input wire logic         CLK,
  input wire logic         RST,
  input wire logic         CE,
  input wire cftc_cmp_type CMP_IN,
  input wire cftc_cfg_type CFG_IN,
  input wire logic         AVS_READ,
  input wire logic         AVS_WRITE,
  input wire logic         AVS_WAITREQUEST,
  input wire logic         CHARGE_GATE_OUT,
  input wire logic         DISCHARGE_GATE_OUT,
  input wire cftc_thr_type THR_OUT,
  input wire logic [4:0]   FAULT_STATUS,
  input wire logic         CFG_READY
);
  logic [4:0]       flag;
  logic [4:0][31:0] lim;
  logic [4:0][31:0] run_q;

  assign flag = {CMP_IN.charge_overcurrent_fault, CMP_IN.load_short_fault, CMP_IN.discharge_overcurrent_fault,
                 CMP_IN.overdischarge_fault, CMP_IN.overcharge_fault};
  assign lim  = {OCC_DLY[CFG_IN.charge_oc_delay_sel], SCC_DLY, OCD_DLY[CFG_IN.discharge_oc_delay_sel],
                 UVP_DLY[CFG_IN.overdischarge_delay_sel], OVP_DLY[CFG_IN.overcharge_delay_sel]};

  // Counts running cycles for which each fault flag has stayed asserted.
  always_ff @(posedge CLK)
  begin
    for (int i = 0; i < 5; i++)
    begin
      if (RST || !flag[i] || !CFG_READY)
        run_q[i] <= '0;
      else if (CE)
        run_q[i] <= run_q[i] + 32'h1;
    end
  end

  for (genvar g = 0; g < 5; g++)
  begin : per_fault
    trip_early_a:
      assert property (@(posedge CLK) disable iff (RST) $rose(FAULT_STATUS[g]) |-> run_q[g] >= lim[g])
      else $error("Fault latched before its delay ran out.");
    trip_late_a:
      assert property (@(posedge CLK) disable iff (RST) run_q[g] == lim[g] + 32'ha |-> FAULT_STATUS[g])
      else $error("Fault not latched after its delay.");
  end

  reset_off_a:
    assert property (@(posedge CLK) disable iff (RST) $fell(RST) |->
      !CHARGE_GATE_OUT && !DISCHARGE_GATE_OUT && FAULT_STATUS == 5'h0 && !CFG_READY)
    else $error("Outputs not cleared by reset.");
  chg_fault_off_a:
    assert property (@(posedge CLK) disable iff (RST) (FAULT_STATUS[0] || FAULT_STATUS[4]) [*3] |-> !CHARGE_GATE_OUT)
    else $error("Charge gate on during a charge fault.");
  dsg_fault_off_a:
    assert property (@(posedge CLK) disable iff (RST) (FAULT_STATUS[3:1] != 3'h0) [*3] |-> !DISCHARGE_GATE_OUT)
    else $error("Discharge gate on during a discharge fault.");
  cfg_hold_a:
    assert property (@(posedge CLK) disable iff (RST) $past(CFG_READY) |-> CFG_READY && $stable(THR_OUT))
    else $error("Options changed after capture.");
  thr_clamp_a:
    assert property (@(posedge CLK) disable iff (RST) THR_OUT.overdischarge_thr <= 5'h10 &&
      THR_OUT.discharge_oc_thr <= 5'h16 && THR_OUT.charge_oc_thr <= 5'h16)
    else $error("Threshold code out of range.");
  bus_wait_a:
    assert property (@(posedge CLK) disable iff (RST) (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=>
      !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
    else $error("Bus answer not one wait cycle.");
endmodule : cftc_checker

bind cftc_top cftc_checker #(.OVP_DLY(OVP_DLY), .UVP_DLY(UVP_DLY), .OCD_DLY(OCD_DLY), .OCC_DLY(OCC_DLY),
  .SCC_DLY(SCC_DLY)) u_chk (.CLK, .RST, .CE, .CMP_IN, .CFG_IN, .AVS_READ, .AVS_WRITE, .AVS_WAITREQUEST,
  .CHARGE_GATE_OUT, .DISCHARGE_GATE_OUT, .THR_OUT, .FAULT_STATUS, .CFG_READY);

// *** test/tb_cell_fault_timer_control.sv ***
// Self-checking bench for the cell fault timer control block.
// Assumes the package, the design, the checker and the FET model are compiled first.
`timescale 1ns/10ps
module tb_cell_fault_timer_control
  import cftc_pkg::*;
();
  localparam logic [3:0][31:0] OVP_T   = {32'h28, 32'h1e, 32'h14, 32'ha};
  localparam logic [3:0][31:0] UVP_T   = {32'h2c, 32'h22, 32'h18, 32'he};
  localparam logic [3:0][31:0] OCD_T   = {32'h30, 32'h26, 32'h1c, 32'h12};
  localparam logic [3:0][31:0] OCC_T   = {32'h24, 32'h1a, 32'h10, 32'hc};
  localparam logic [31:0]      SCC_T   = 32'h5;
  localparam logic [31:0]      REC_T   = 32'h8;
  localparam int               FPOS[5] = '{10, 8, 6, 5, 3};
  localparam int               RPOS[5] = '{9, 7, 4, 4, 2};

  logic         clk;
  logic         rst;
  logic         ce;
  cftc_cmp_type cmp;
  cftc_cfg_type cfg;
  logic [3:0]   addr;
  logic         rd;
  logic         wr;
  logic [31:0]  wdata;
  logic [31:0]  rdata;
  logic         waitreq;
  logic         chg;
  logic         dsg;
  cftc_thr_type thr;
  logic [4:0]   fstat;
  logic         ready;
  logic         chg_on;
  logic         dsg_on;
  logic [31:0]  q;
  int           failures;
  int           cmp_count;

  cftc_top #(.OVP_DLY(OVP_T), .UVP_DLY(UVP_T), .OCD_DLY(OCD_T), .OCC_DLY(OCC_T), .SCC_DLY(SCC_T), .REC_DLY(REC_T)) dut
  (.CLK(clk), .RST(rst), .CE(ce), .CMP_IN(cmp), .CFG_IN(cfg), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
   .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
   .CHARGE_GATE_OUT(chg), .DISCHARGE_GATE_OUT(dsg), .THR_OUT(thr), .FAULT_STATUS(fstat), .CFG_READY(ready));
  cftc_fet_model fet (.chg_gate(chg), .dsg_gate(dsg), .chg_on(chg_on), .dsg_on(dsg_on));

  task automatic results();
    if (failures == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic timeout();
    failures++;
    $display("BAD %0t wait timed out", $time);
    results();
  endtask : timeout

  function automatic logic gate(input logic is_chg);
    return is_chg ? chg : dsg;
  endfunction : gate

  task automatic wait_gate(input logic is_chg, input logic val, input int max);
    for (int i = 0; i < max; i++)
    begin
      @(negedge clk);
      if (gate(is_chg) === val)
        return;
    end
    timeout();
  endtask : wait_gate

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    addr <= a;
    rd <= !w;
    wr <= w;
    wdata <= d;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk);
      if (waitreq === 1'b0)
        break;
    end
    if (i == 20)
      timeout();
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic set_fault(input int idx, input logic v);
    cmp[FPOS[idx]] <= v;
    cmp[RPOS[idx]] <= !v;
  endtask : set_fault

  task automatic trip(input logic is_chg, input int idx, input int dly);
    @(posedge clk);
    set_fault(idx, 1'b1);
    repeat (dly) @(posedge clk);
    @(negedge clk);
    chk(gate(is_chg), 1'b1);
    wait_gate(is_chg, 1'b0, 12);
    chk(fstat[idx], 1'b1);
  endtask : trip

  task automatic recover(input logic is_chg, input int idx);
    @(posedge clk);
    set_fault(idx, 1'b0);
    repeat (REC_T) @(posedge clk);
    @(negedge clk);
    chk(gate(is_chg), 1'b0);
    wait_gate(is_chg, 1'b1, 16);
    chk(fstat, 5'h0);
  endtask : recover

  task automatic do_reset(input logic allow);
    @(posedge clk);
    rst <= 1'b1;
    cfg.zero_volt_allow <= allow;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk({chg, dsg, fstat, ready}, 8'h0);
    @(posedge clk);
    rst <= 1'b0;
    wait_gate(1'b1, 1'b1, 40);
    wait_gate(1'b0, 1'b1, 40);
    chk({ready, chg_on, dsg_on}, 3'h7);
    chk(thr, {2'h3, 5'h16, 5'h16, 5'h10, 4'hf});
  endtask : do_reset

  task automatic s_faults();
    trip(1'b1, FI_OVP, OVP_T[1]);
    recover(1'b1, FI_OVP);
    trip(1'b0, FI_UVP, UVP_T[2]);
    recover(1'b0, FI_UVP);
    trip(1'b1, FI_OCC, OCC_T[0]);
    recover(1'b1, FI_OCC);
  endtask : s_faults

  task automatic s_recur();
    trip(1'b0, FI_OCD, OCD_T[3]);
    @(posedge clk);
    set_fault(FI_OCD, 1'b0);
    repeat (5) @(posedge clk);
    set_fault(FI_OCD, 1'b1);
    repeat (2 * REC_T) @(negedge clk);
    chk({dsg, fstat[FI_OCD]}, 2'h1);
    recover(1'b0, FI_OCD);
  endtask : s_recur

  task automatic s_short();
    @(posedge clk);
    ce <= 1'b0;
    set_fault(FI_SCC, 1'b1);
    repeat (30) @(negedge clk);
    chk(dsg, 1'b1);
    @(posedge clk);
    ce <= 1'b1;
    repeat (SCC_T) @(negedge clk);
    chk(dsg, 1'b1);
    wait_gate(1'b0, 1'b0, 12);
    recover(1'b0, FI_SCC);
  endtask : s_short

  task automatic s_glitch();
    @(posedge clk);
    set_fault(FI_OVP, 1'b1);
    repeat (OVP_T[1] - 8) @(posedge clk);
    set_fault(FI_OVP, 1'b0);
    repeat (40) @(negedge clk);
    chk({chg, fstat}, 6'h20);
  endtask : s_glitch

  task automatic s_bus();
    bus(1'b0, REG_STATUS, 32'h0);
    chk(q, 32'h160);
    bus(1'b0, REG_CFG, 32'h0);
    chk(q, 32'(cfg));
    bus(1'b0, 4'hc, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, REG_CTRL, 32'h1);
    wait_gate(1'b1, 1'b0, 8);
    wait_gate(1'b0, 1'b0, 8);
    bus(1'b0, REG_CTRL, 32'h0);
    chk(q, 32'h1);
    bus(1'b1, REG_CTRL, 32'h0);
    wait_gate(1'b1, 1'b1, 8);
    wait_gate(1'b0, 1'b1, 8);
    @(posedge clk);
    cfg.overcharge_thr_sel <= 4'h0;
    repeat (8) @(negedge clk);
    chk(thr.overcharge_thr, 4'hf);
    @(posedge clk);
    cfg.overcharge_thr_sel <= 4'hf;
  endtask : s_bus

  task automatic s_zero();
    do_reset(1'b1);
    @(posedge clk);
    cmp.zero_volt_charge_inhibit <= 1'b1;
    wait_gate(1'b1, 1'b0, 12);
    @(posedge clk);
    cmp.zero_volt_charge_start <= 1'b1;
    wait_gate(1'b1, 1'b1, 12);
    @(posedge clk);
    cmp.zero_volt_charge_inhibit <= 1'b0;
    cmp.zero_volt_charge_start <= 1'b0;
    do_reset(1'b0);
    @(posedge clk);
    cmp.zero_volt_charge_inhibit <= 1'b1;
    wait_gate(1'b1, 1'b0, 12);
    @(posedge clk);
    cmp.zero_volt_charge_inhibit <= 1'b0;
    wait_gate(1'b1, 1'b1, 12);
  endtask : s_zero

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial
  begin
    failures = 0;
    cmp_count = 0;
    rst = 1'b1;
    ce = 1'b1;
    cmp = 11'h294;
    cfg = {1'b0, 2'h0, 2'h3, 2'h2, 2'h1, 2'h3, 5'h1f, 5'h16, 5'h1f, 4'hf};
    addr = 4'h0;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0;
    do_reset(1'b0);
    s_bus();
    s_faults();
    s_recur();
    s_short();
    s_glitch();
    s_zero();
    results();
  end
endmodule : tb_cell_fault_timer_control
